// File: csc_cal_if.sv
// Handshake between the control bank and the calibration sequencer
`timescale 1ns/1ps
`default_nettype none
interface csc_cal_if;
    logic start;
    logic hold;
    logic busy;
    logic held;
    modport ctrl (output start, output hold, input busy, input held);
    modport seq  (input start, input hold, output busy, output held);
endinterface
`default_nettype wire

// File: csc_ctrl_regs.sv
// Control bank of the two-output clock synthesizer over Avalon-MM
//
// Functional notes
// - Per-output format bit: 0 one driver, 1 other
// - Bypass bit routes active reference to output
// - 17-bit pre-divider and lower feedback divider
// - Upper loop: 8-bit integer, 18-bit fraction
// - Each output has an 8-bit post divider
// - Recalibrate bit forces calibration; software clears it
// - Calibration runs by itself after power-up
// - Output on only when bit and pin agree
// - Both enable bits come out of reset set
// - Two-bit policy picks manual or automatic switching
// - Select bit: register choice, primary, or ignored
// - Doubler bit turns on crystal doubler
// - ADC rate divides crystal by 16/8/4/2
// - Lock window two to sixteen microseconds
// - PLL mode: low, synth, high, high
// - Disabled output pair goes high impedance
// - Enable pins pulled up, idle as enabled
//
// Implementation choices: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module csc_ctrl_regs
    import csc_pkg::*;
#(
    parameter int unsigned CAL_CYCLES = 256
) (
    input  wire logic                  clock_i,
    input  wire logic                  rst_i,
    input  wire logic [ADDR_W-1:0]     avs_address_i,
    input  wire logic                  avs_read_i,
    input  wire logic                  avs_write_i,
    input  wire logic [DATA_W-1:0]     avs_writedata_i,
    input  wire logic [3:0]            avs_byteenable_i,
    output logic      [DATA_W-1:0]     avs_readdata_o,
    output logic                       avs_waitrequest_o,
    input  wire logic                  out0_enable_pin_i,
    input  wire logic                  out1_enable_pin_i,
    input  wire logic                  ref_select_pin_i,
    input  wire logic                  ref_input_a_bad_i,
    input  wire logic                  ref_input_b_bad_i,
    output logic                       out0_format_sel_o,
    output logic                       out1_format_sel_o,
    output logic                       out0_ref_passthru_o,
    output logic                       out1_ref_passthru_o,
    output logic                       out_pair_a_oe_o,
    output logic                       out_pair_b_oe_o,
    output logic      [PREDIV_W-1:0]   ref_pre_div_o,
    output logic      [LOWER_W-1:0]    lower_loop_fb_div_o,
    output logic      [UINT_W-1:0]     upper_loop_int_div_o,
    output logic      [FRAC_W-1:0]     upper_loop_frac_div_o,
    output logic      [POST_W-1:0]     out0_post_div_o,
    output logic      [POST_W-1:0]     out1_post_div_o,
    output logic      [BW_W-1:0]       loop_bandwidth_cfg_o,
    output logic                       xtal_doubler_en_o,
    output logic      [ADC_DIV_W-1:0]  adc_clk_div_o,
    output logic      [LOCK_CYC_W-1:0] lock_window_cycles_o,
    output var csc_pll_mode_type       pll_mode_o,
    output logic                       active_input_o,
    output logic                       vco_cal_busy_o,
    output logic                       vco_hold_o
);

    logic [DATA_W-1:0]  regs_r [REG_NUM];
    logic [DATA_W-1:0]  rdata_r;
    logic [DATA_W-1:0]  rd_word;
    logic [DATA_W-1:0]  status_w;
    logic               ack_r;
    logic               recal_d_r;
    logic [SYNC_N-1:0]  s1_r;
    logic [SYNC_N-1:0]  s2_r;
    logic [SYNC_N-1:0]  s3_r;
    logic [SYNC_N-1:0]  stab_r;
    logic [SYNC_N-1:0]  stab_nxt;
    logic [SYNC_N-1:0]  raw_w;
    logic               active_r;
    logic               active_nxt;
    logic               oe_a_r;
    logic               oe_b_r;
    logic [ADC_DIV_W-1:0]  adc_r;
    logic [LOCK_CYC_W-1:0] lockw_r;
    csc_pll_mode_type   mode_r;
    csc_sel_policy_type policy_w;

    csc_cal_if cal_bus ();

    // Bus decode: one wait state on every access
    wire       bus_req = avs_read_i | avs_write_i;
    wire [3:0] idx     = avs_address_i[ADDR_W-1:2];
    wire       in_bank = (idx < 4'(REG_NUM));
    wire       wr_hit  = avs_write_i & ack_r & in_bank;
    wire       rd_take = avs_read_i & ~ack_r;

    assign avs_waitrequest_o = bus_req & ~ack_r;
    assign avs_readdata_o    = rdata_r;

    // Reserved bits and unmapped words read zero
    assign rd_word = in_bank ? (regs_r[idx[2:0]] & REG_MASK[idx[2:0]]) :
                     (idx == 4'(IDX_STATUS)) ? status_w : '0;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ack_r   <= 1'b0;
            rdata_r <= '0;
        end else begin
            ack_r <= bus_req & ~ack_r;
            if (rd_take) begin
                rdata_r <= rd_word;
            end
        end
    end

    // Reserved positions are masked off, so stray ones never stick
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < REG_NUM; i++) begin
                regs_r[i] <= REG_RST[i];
            end
        end else begin
            for (int i = 0; i < REG_NUM; i++) begin
                if (wr_hit && idx == 4'(i)) begin
                    regs_r[i] <= be_merge(regs_r[i], avs_writedata_i,
                                          avs_byteenable_i) & REG_MASK[i];
                end
            end
        end
    end

    // Field taps
    wire [DATA_W-1:0] oc_w   = regs_r[IDX_OUTCTL];
    wire [DATA_W-1:0] loop_w = regs_r[IDX_LOOP];
    wire [DATA_W-1:0] post_w = regs_r[IDX_POST];
    wire              en0_w  = oc_w[BIT_EN0];
    wire              en1_w  = oc_w[BIT_EN1];
    wire              recal_w = oc_w[BIT_RECAL];
    wire              prim_w = loop_w[PRIM_BIT];
    wire [1:0]        adc_f  = loop_w[ADC_LSB +: 2];
    wire [1:0]        lock_f = loop_w[LOCKW_LSB +: 2];
    wire [1:0]        mode_f = loop_w[MODE_LSB +: 2];

    assign policy_w = csc_sel_policy_type'(loop_w[POLICY_LSB +: 2]);

    assign out0_format_sel_o     = oc_w[BIT_FMT0];
    assign out1_format_sel_o     = oc_w[BIT_FMT1];
    assign out0_ref_passthru_o   = oc_w[BIT_PASS0];
    assign out1_ref_passthru_o   = oc_w[BIT_PASS1];
    assign xtal_doubler_en_o     = oc_w[BIT_DBL];
    assign ref_pre_div_o         = regs_r[IDX_PREDIV][PREDIV_W-1:0];
    assign lower_loop_fb_div_o   = regs_r[IDX_LOWER][LOWER_W-1:0];
    assign upper_loop_int_div_o  = regs_r[IDX_UINT][UINT_W-1:0];
    assign upper_loop_frac_div_o = regs_r[IDX_FRAC][FRAC_W-1:0];
    assign out0_post_div_o       = post_w[POST0_LSB +: POST_W];
    assign out1_post_div_o       = post_w[POST1_LSB +: POST_W];
    assign loop_bandwidth_cfg_o  = loop_w[BW_LSB +: BW_W];
    assign adc_clk_div_o         = adc_r;
    assign lock_window_cycles_o  = lockw_r;
    assign pll_mode_o            = mode_r;
    assign active_input_o        = active_r;
    assign out_pair_a_oe_o       = oe_a_r;
    assign out_pair_b_oe_o       = oe_b_r;

    // Pin synchronisers: a change counts once stages two and three agree
    assign raw_w = {ref_input_b_bad_i, ref_input_a_bad_i, ref_select_pin_i,
                    out1_enable_pin_i, out0_enable_pin_i};
    assign stab_nxt = (stab_r & (s2_r ^ s3_r)) | (s3_r & ~(s2_r ^ s3_r));

    // Reset value mirrors the weak pull-up on a floating enable pin
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            s1_r   <= SYNC_RST;
            s2_r   <= SYNC_RST;
            s3_r   <= SYNC_RST;
            stab_r <= SYNC_RST;
        end else begin
            s1_r   <= raw_w;
            s2_r   <= s1_r;
            s3_r   <= s2_r;
            stab_r <= stab_nxt;
        end
    end

    wire a_bad_w = stab_r[SY_ABAD];
    wire b_bad_w = stab_r[SY_BBAD];
    wire cur_bad = active_r ? b_bad_w : a_bad_w;
    wire alt_bad = active_r ? a_bad_w : b_bad_w;
    wire pri_bad = prim_w ? b_bad_w : a_bad_w;
    wire sec_bad = prim_w ? a_bad_w : b_bad_w;

    // Automatic policies, both inputs bad: keep the current one, the loop holds over
    always_comb begin
        active_nxt = active_r;
        case (policy_w)
            SEL_PIN:      active_nxt = stab_r[SY_PIN];
            SEL_REG:      active_nxt = prim_w;
            SEL_AUTO_NR: begin
                if (cur_bad && !alt_bad) begin
                    active_nxt = ~active_r;
                end
            end
            SEL_AUTO_REV: begin
                if (!pri_bad) begin
                    active_nxt = prim_w;
                end else if (!sec_bad) begin
                    active_nxt = ~prim_w;
                end
            end
            default:      active_nxt = active_r;
        endcase
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            active_r <= 1'b0;
            oe_a_r   <= 1'b0;
            oe_b_r   <= 1'b0;
            adc_r    <= ADC_DIV16;
            lockw_r  <= LOCK_CYC_W'(LOCK_BASE_CYC);
            mode_r   <= PLL_LOW_BW;
        end else begin
            active_r <= active_nxt;
            oe_a_r   <= en0_w & stab_r[SY_OE0];
            oe_b_r   <= en1_w & stab_r[SY_OE1];
            adc_r    <= adc_div_decode(adc_f);
            lockw_r  <= lock_cyc_decode(lock_f);
            mode_r   <= pll_mode_decode(mode_f);
        end
    end

    // Calibration: a rising edge of the bit starts a run when the sequencer is idle
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            recal_d_r <= 1'b0;
        end else begin
            recal_d_r <= recal_w;
        end
    end

    assign cal_bus.start  = recal_w & ~recal_d_r;
    assign cal_bus.hold   = recal_w;
    assign vco_cal_busy_o = cal_bus.busy;
    assign vco_hold_o     = cal_bus.busy | cal_bus.held;

    csc_vco_cal #(
        .CAL_CYCLES (CAL_CYCLES)
    ) u_cal (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .cal     (cal_bus.seq)
    );

    assign status_w = {{(DATA_W-ST_NUM){1'b0}}, b_bad_w, a_bad_w,
                       cal_bus.held, cal_bus.busy, active_r,
                       oe_b_r, oe_a_r};

    property p_oe_a_gate;
        @(posedge clock_i) disable iff (rst_i)
        !en0_w |=> !out_pair_a_oe_o;
    endproperty
    a_oe_a_gate: assert property (p_oe_a_gate)
        else $error("output a enabled with its bit clear");

    property p_oe_b_pin;
        @(posedge clock_i) disable iff (rst_i)
        (en1_w && stab_r[SY_OE1]) ##1 (en1_w && stab_r[SY_OE1])
            |-> out_pair_b_oe_o;
    endproperty
    a_oe_b_pin: assert property (p_oe_b_pin)
        else $error("output b not enabled by bit and pin");

    property p_adc_div;
        @(posedge clock_i) disable iff (rst_i)
        (adc_f == 2'b10) ##1 (adc_f == 2'b10) |-> adc_clk_div_o == ADC_DIV4;
    endproperty
    a_adc_div: assert property (p_adc_div)
        else $error("adc rate decode wrong");

    property p_lock_win;
        @(posedge clock_i) disable iff (rst_i)
        (lock_f == 2'b11) |=> lock_window_cycles_o == LOCK_CYC_W'(3200);
    endproperty
    a_lock_win: assert property (p_lock_win)
        else $error("lock window not sixteen microseconds");

    property p_mode_high;
        @(posedge clock_i) disable iff (rst_i)
        (mode_f == 2'b11) |=> pll_mode_o == PLL_HIGH_BW;
    endproperty
    a_mode_high: assert property (p_mode_high)
        else $error("mode three not high bandwidth");

    property p_reg_sel;
        @(posedge clock_i) disable iff (rst_i)
        (policy_w == SEL_REG) |=> active_input_o == $past(prim_w);
    endproperty
    a_reg_sel: assert property (p_reg_sel)
        else $error("register select not followed");

    property p_nonrev;
        @(posedge clock_i) disable iff (rst_i)
        (policy_w == SEL_AUTO_NR && !cur_bad) |=> $stable(active_input_o);
    endproperty
    a_nonrev: assert property (p_nonrev)
        else $error("non-revertive switched from a good input");

    property p_one_wait;
        @(posedge clock_i) disable iff (rst_i)
        (bus_req && avs_waitrequest_o) |=> !avs_waitrequest_o;
    endproperty
    a_one_wait: assert property (p_one_wait)
        else $error("bus answer took more than one wait state");

endmodule
`default_nettype wire

// File: csc_ctrl_regs_tb_top.sv
// Self-checking bench of the clock synthesizer control bank
`timescale 1ns/1ps
`default_nettype none
module csc_ctrl_regs_tb_top;
    import csc_pkg::*;
    localparam int unsigned CAL_N = 4;
    // {exp, b bad, a bad, pin, policy, primary}
    localparam logic [6:0] SEL_TAB [9] = '{7'h47, 7'h06, 7'h01, 7'h49,
        7'h45, 7'h25, 7'h45, 7'h23, 7'h03};
    logic              clock_i = 1'b0;
    logic              rst_i   = 1'b1;
    logic [ADDR_W-1:0] adr     = '0;
    logic              rd      = 1'b0;
    logic              wr      = 1'b0;
    logic [DATA_W-1:0] wdat    = '0;
    logic [3:0]        be      = 4'hf;
    logic              pin0    = 1'b1;
    logic              pin1    = 1'b1;
    logic              psel    = 1'b0;
    logic              abad    = 1'b0;
    logic              bbad    = 1'b0;
    logic [DATA_W-1:0] rdat, q, d, seed;
    logic [DATA_W-1:0] exp_r [REG_NUM];
    logic              wreq, fmt0, fmt1, pas0, pas1, oea, oeb, dbl, act;
    logic              busy, hold;
    logic [16:0]       prediv, lower;
    logic [17:0]       frac;
    logic [7:0]        uint, post0, post1;
    logic [6:0]        bw;
    logic [4:0]        adc;
    logic [12:0]       lockc;
    csc_pll_mode_type  mode;
    int                n_fail   = 0;
    int                n_checks = 0;
    int                cyc      = 0;

    csc_ctrl_regs #(.CAL_CYCLES(CAL_N)) i_dut (
        .clock_i(clock_i), .rst_i(rst_i), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
        .avs_byteenable_i(be), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wreq), .out0_enable_pin_i(pin0),
        .out1_enable_pin_i(pin1), .ref_select_pin_i(psel),
        .ref_input_a_bad_i(abad), .ref_input_b_bad_i(bbad),
        .out0_format_sel_o(fmt0), .out1_format_sel_o(fmt1),
        .out0_ref_passthru_o(pas0), .out1_ref_passthru_o(pas1),
        .out_pair_a_oe_o(oea), .out_pair_b_oe_o(oeb),
        .ref_pre_div_o(prediv), .lower_loop_fb_div_o(lower),
        .upper_loop_int_div_o(uint), .upper_loop_frac_div_o(frac),
        .out0_post_div_o(post0), .out1_post_div_o(post1),
        .loop_bandwidth_cfg_o(bw), .xtal_doubler_en_o(dbl),
        .adc_clk_div_o(adc), .lock_window_cycles_o(lockc),
        .pll_mode_o(mode), .active_input_o(act),
        .vco_cal_busy_o(busy), .vco_hold_o(hold));

    always #2.5 clock_i = ~clock_i;

    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Holds the request until waitrequest is sampled low
    task automatic bus(input logic w, input int idx, input logic [31:0] v);
        int n;
        @(posedge clock_i);
        adr  <= ADDR_W'(idx * 4);
        wr   <= w;
        rd   <= ~w;
        wdat <= v;
        n = 0;
        @(posedge clock_i);
        // A hang ends at the bench timeout, not here
        while (wreq !== 1'b0) begin
            @(posedge clock_i);
            n++;
        end
        q = rdat;
        chk(32'(n < 20), 32'h1);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    task automatic wait_busy(input logic v);
        int n;
        n = 0;
        while (busy !== v) begin
            @(posedge clock_i);
            n++;
        end
        chk(32'(n < 50), 32'h1);
    endtask

    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    initial begin
        seed = 32'd2827;
        repeat (16) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        chk(32'(busy), 32'h1);
        for (int i = 0; i < REG_NUM; i++) begin
            bus(1'b0, i, '0);
            chk(q, (i == IDX_OUTCTL) ? 32'h30 : 32'h0);
        end
        chk({fmt0, fmt1, pas0, pas1, oea, oeb, dbl, act}, 32'h0c);
        chk({adc, lockc, 2'(mode)}, {5'h10, 13'd400, 2'b00});
        chk({busy, hold}, 32'h0);
        // Random fields; reserved positions always written as zero
        for (int r = 0; r < 3; r++) begin
            for (int i = 0; i < REG_NUM; i++) begin
                seed = lfsr(seed);
                d = (i == IDX_OUTCTL) ? (seed & ~32'h40) : seed;
                d = d & REG_MASK[i];
                bus(1'b1, i, d);
                exp_r[i] = d & REG_MASK[i];
                bus(1'b0, i, '0);
                chk(q, exp_r[i]);
            end
            repeat (6) @(posedge clock_i);
            chk(32'(frac), 32'(exp_r[0][17:0]));
            chk(32'(prediv), 32'(exp_r[1][16:0]));
            chk(32'(lower), 32'(exp_r[2][16:0]));
            chk(32'(uint), 32'(exp_r[3][7:0]));
            chk(32'({post1, post0}), 32'(exp_r[4][15:0]));
            chk({dbl, fmt1, fmt0, pas1, pas0}, 32'({exp_r[5][7],
                exp_r[5][3:0]}));
            chk({oeb, oea}, 32'(exp_r[5][5:4]));
            chk(32'(bw), 32'(exp_r[6][6:0]));
        end
        be <= 4'h2;
        bus(1'b1, IDX_POST, 32'h0000ffff);
        be <= 4'hf;
        bus(1'b0, IDX_POST, '0);
        chk(q, {16'h0, 8'hff, exp_r[4][7:0]});
        bus(1'b1, 15, 32'hffffffff);
        bus(1'b0, 15, '0);
        chk(q, 32'h0);
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, IDX_LOOP, (k << 18) | (k << 20) | (k << 8));
            repeat (3) @(posedge clock_i);
            chk(32'(adc), 32'h10 >> k);
            chk(32'(lockc), 32'd400 << k);
            chk(32'(mode), (k == 0) ? 0 : (k == 1) ? 1 : 2);
        end
        for (int k = 0; k < 16; k++) begin
            bus(1'b1, IDX_OUTCTL, (k & 3) << 4);
            pin0 <= k[2];
            pin1 <= k[3];
            repeat (6) @(posedge clock_i);
            chk({oeb, oea}, k & (k >> 2) & 3);
        end
        pin0 <= 1'b1;
        pin1 <= 1'b1;
        foreach (SEL_TAB[k]) begin
            bus(1'b1, IDX_LOOP, {SEL_TAB[k][0], 2'b0, SEL_TAB[k][2:1],
                12'h0});
            psel <= SEL_TAB[k][3];
            abad <= SEL_TAB[k][4];
            bbad <= SEL_TAB[k][5];
            repeat (8) @(posedge clock_i);
            chk(32'(act), 32'(SEL_TAB[k][6]));
        end
        // Dividers were changed above, so a recalibration is due
        bus(1'b1, IDX_OUTCTL, 32'h70);
        wait_busy(1'b1);
        wait_busy(1'b0);
        repeat (3) @(posedge clock_i);
        chk(32'(hold), 32'h1);
        bus(1'b1, IDX_OUTCTL, 32'h30);
        repeat (3) @(posedge clock_i);
        chk({busy, hold}, 32'h0);
        bus(1'b0, IDX_STATUS, '0);
        chk(q, 32'h03);
        tally_and_finish();
    end
endmodule
`default_nettype wire

// File: csc_pkg.sv
// Shared constants, field layout and types of the clock synthesizer controls
package csc_pkg;

    localparam int unsigned CLK_MHZ  = 200;
    localparam int unsigned ADDR_W   = 6;
    localparam int unsigned DATA_W   = 32;
    localparam int unsigned REG_NUM  = 7;

    // Word indices; byte address is four times the index
    localparam int unsigned IDX_FRAC   = 0;
    localparam int unsigned IDX_PREDIV = 1;
    localparam int unsigned IDX_LOWER  = 2;
    localparam int unsigned IDX_UINT   = 3;
    localparam int unsigned IDX_POST   = 4;
    localparam int unsigned IDX_OUTCTL = 5;
    localparam int unsigned IDX_LOOP   = 6;
    localparam int unsigned IDX_STATUS = 7;

    localparam int unsigned FRAC_W   = 18;
    localparam int unsigned PREDIV_W = 17;
    localparam int unsigned LOWER_W  = 17;
    localparam int unsigned UINT_W   = 8;
    localparam int unsigned POST_W   = 8;
    localparam int unsigned POST0_LSB = 0;
    localparam int unsigned POST1_LSB = 8;

    localparam int unsigned BIT_PASS0 = 0;
    localparam int unsigned BIT_PASS1 = 1;
    localparam int unsigned BIT_FMT0  = 2;
    localparam int unsigned BIT_FMT1  = 3;
    localparam int unsigned BIT_EN0   = 4;
    localparam int unsigned BIT_EN1   = 5;
    localparam int unsigned BIT_RECAL = 6;
    localparam int unsigned BIT_DBL   = 7;

    localparam int unsigned BW_W       = 7;
    localparam int unsigned BW_LSB     = 0;
    localparam int unsigned MODE_LSB   = 8;
    localparam int unsigned POLICY_LSB = 12;
    localparam int unsigned PRIM_BIT   = 16;
    localparam int unsigned ADC_LSB    = 18;
    localparam int unsigned LOCKW_LSB  = 20;

    localparam logic [DATA_W-1:0] REG_MASK [REG_NUM] = '{
        32'h0003ffff, 32'h0001ffff, 32'h0001ffff, 32'h000000ff,
        32'h0000ffff, 32'h000000ff, 32'h003d337f};
    // Output enable bits come up set
    localparam logic [DATA_W-1:0] REG_RST [REG_NUM] = '{
        32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000,
        32'h00000000, 32'h00000030, 32'h00000000};

    localparam int unsigned ST_NUM = 7;

    // Synchroniser lanes; pulled-up pins idle high
    localparam int unsigned SY_OE0  = 0;
    localparam int unsigned SY_OE1  = 1;
    localparam int unsigned SY_PIN  = 2;
    localparam int unsigned SY_ABAD = 3;
    localparam int unsigned SY_BBAD = 4;
    localparam int unsigned SYNC_N  = 5;
    localparam logic [SYNC_N-1:0] SYNC_RST = 5'h03;

    localparam int unsigned ADC_DIV_W = 5;
    localparam logic [ADC_DIV_W-1:0] ADC_DIV16 = 5'h10;
    localparam logic [ADC_DIV_W-1:0] ADC_DIV8  = 5'h08;
    localparam logic [ADC_DIV_W-1:0] ADC_DIV4  = 5'h04;
    localparam logic [ADC_DIV_W-1:0] ADC_DIV2  = 5'h02;

    localparam int unsigned LOCK_BASE_NS  = 2000;
    localparam int unsigned LOCK_BASE_CYC = (LOCK_BASE_NS * CLK_MHZ) / 1000;
    localparam int unsigned LOCK_CYC_W    = 13;

    typedef enum logic [1:0] {
        PLL_LOW_BW  = 2'b00,
        PLL_SYNTH   = 2'b01,
        PLL_HIGH_BW = 2'b10
    } csc_pll_mode_type;

    typedef enum logic [1:0] {
        SEL_PIN      = 2'b00,
        SEL_AUTO_NR  = 2'b01,
        SEL_AUTO_REV = 2'b10,
        SEL_REG      = 2'b11
    } csc_sel_policy_type;

    typedef enum logic [1:0] {
        CAL_IDLE = 2'b00,
        CAL_RUN  = 2'b01,
        CAL_HOLD = 2'b10
    } csc_cal_state_type;

    function automatic csc_pll_mode_type pll_mode_decode(logic [1:0] f);
        csc_pll_mode_type m;
        m = PLL_HIGH_BW;
        if (f == 2'b00) begin
            m = PLL_LOW_BW;
        end else if (f == 2'b01) begin
            m = PLL_SYNTH;
        end
        return m;
    endfunction

    function automatic logic [ADC_DIV_W-1:0] adc_div_decode(logic [1:0] f);
        logic [ADC_DIV_W-1:0] d;
        d = ADC_DIV2;
        case (f)
            2'b00:   d = ADC_DIV16;
            2'b01:   d = ADC_DIV8;
            2'b10:   d = ADC_DIV4;
            default: d = ADC_DIV2;
        endcase
        return d;
    endfunction

    function automatic logic [LOCK_CYC_W-1:0] lock_cyc_decode(logic [1:0] f);
        logic [LOCK_CYC_W-1:0] c;
        c = LOCK_CYC_W'(LOCK_BASE_CYC) << f;
        return c;
    endfunction

    function automatic logic [DATA_W-1:0] be_merge(logic [DATA_W-1:0] old,
                                                   logic [DATA_W-1:0] nw,
                                                   logic [3:0] be);
        logic [DATA_W-1:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

endpackage

// File: csc_vco_cal.sv
// VCO calibration sequencer: power-up run, forced runs and hold
`timescale 1ns/1ps
`default_nettype none
module csc_vco_cal
    import csc_pkg::*;
#(
    parameter int unsigned CAL_CYCLES = 256
) (
    input  wire logic clock_i,
    input  wire logic rst_i,
    csc_cal_if.seq    cal
);
    localparam int unsigned CNT_W = $clog2(CAL_CYCLES) + 1;
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CAL_CYCLES - 1);

    generate
        if (CAL_CYCLES < 1) begin : g_bad
            $error("CAL_CYCLES must be at least one");
        end
    endgenerate

    csc_cal_state_type state_r;
    csc_cal_state_type state_nxt;
    logic [CNT_W-1:0]  cnt_r;
    logic [CNT_W-1:0]  cnt_nxt;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            CAL_RUN: begin
                // Bit still set at the end: stay out of normal operation
                if (cnt_r == CNT_LAST) begin
                    state_nxt = cal.hold ? CAL_HOLD : CAL_IDLE;
                end
            end
            CAL_IDLE: begin
                if (cal.start) begin
                    state_nxt = CAL_RUN;
                end
            end
            CAL_HOLD: begin
                if (!cal.hold) begin
                    state_nxt = CAL_IDLE;
                end
            end
            default: state_nxt = CAL_IDLE;
        endcase
    end

    assign cnt_nxt  = (state_r == CAL_RUN) ? cnt_r + 1'b1 : '0;
    assign cal.busy = (state_r == CAL_RUN);
    assign cal.held = (state_r == CAL_HOLD);

    // Reset lands in a run so power-up calibrates unprompted
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state_r <= CAL_RUN;
            cnt_r   <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    property p_cal_start;
        @(posedge clock_i) disable iff (rst_i)
        (cal.start && state_r == CAL_IDLE) |=> cal.busy;
    endproperty
    a_cal_start: assert property (p_cal_start)
        else $error("forced calibration did not start");

    property p_hold_stays;
        @(posedge clock_i) disable iff (rst_i)
        (cal.held && cal.hold) |=> cal.held && !cal.busy;
    endproperty
    a_hold_stays: assert property (p_hold_stays)
        else $error("left hold while recalibrate bit set");

endmodule
`default_nettype wire
